// >>> rtl/clear_active_enable.sv
// distributor clear-active and clear-enable word arrays, normal and extended range
`timescale 1ns/1ps
module clear_active_enable
    import dist_clear_pkg::*;
#(
    parameter int NUM_WORDS     = 2,
    parameter int NUM_PE        = 8,
    parameter bit EXT_SUPPORTED = 1'b1,
    parameter int EXT_WORDS     = 1,
    parameter bit SGI_ALWAYS_ON = 1'b0,
    parameter int WP_CYCLES     = PROPAGATE_CYCLES
)(
    // clock and reset
    input  wire logic                            i_sys_clk,
    input  wire logic                            i_srst,
    // register access
    input  wire logic                            i_reg_valid,
    input  wire logic                            i_reg_write,
    input  wire logic [ADDR_W-1:0]               i_reg_addr,
    input  wire logic [DATA_W-1:0]               i_reg_wdata,
    input  wire logic                            i_reg_secure,
    input  wire logic [PE_NUM_W-1:0]             i_reg_pe,
    output logic                                 o_reg_ack,
    output logic [DATA_W-1:0]                    o_reg_rdata,
    // distributor control
    input  wire logic                            i_security_disable,
    input  wire logic                            i_are_secure,
    input  wire logic                            i_are_nonsecure,
    input  wire logic                            i_other_write_pending,
    output logic                                 o_write_pending,
    // per-interrupt group and grant
    input  wire logic [31:0]                     i_secure_group_private,
    input  wire logic [(NUM_WORDS-1)*32-1:0]     i_secure_group_shared,
    input  wire logic [EXT_WORDS*32-1:0]         i_secure_group_ext,
    input  wire logic [31:0]                     i_ns_grant_private,
    input  wire logic [(NUM_WORDS-1)*32-1:0]     i_ns_grant_shared,
    // state set by the rest of the distributor
    input  wire logic [NUM_PE*32-1:0]            i_activate_private,
    input  wire logic [(NUM_WORDS-1)*32-1:0]     i_activate_shared,
    input  wire logic [EXT_WORDS*32-1:0]         i_activate_ext,
    input  wire logic [NUM_PE*32-1:0]            i_enable_private,
    input  wire logic [(NUM_WORDS-1)*32-1:0]     i_enable_shared,
    input  wire logic [EXT_WORDS*32-1:0]         i_enable_ext,
    // current state
    output logic [NUM_PE*32-1:0]                 o_active_private,
    output logic [(NUM_WORDS-1)*32-1:0]          o_active_shared,
    output logic [EXT_WORDS*32-1:0]              o_active_ext,
    output logic [NUM_PE*32-1:0]                 o_enable_private,
    output logic [(NUM_WORDS-1)*32-1:0]          o_enable_shared,
    output logic [EXT_WORDS*32-1:0]              o_enable_ext
);

    localparam int NSH  = (NUM_WORDS - 1) * 32;
    localparam int NEXT = EXT_WORDS * 32;
    localparam int NPRV = NUM_PE * 32;

    // ==========================================================
    // elaboration check
    if (NUM_WORDS < 2 || NUM_WORDS > MAX_WORDS || NUM_PE < 1 || NUM_PE > MAX_PE ||
        EXT_WORDS < 1 || EXT_WORDS > MAX_WORDS) begin : g_bad_params
        $error("clear_active_enable: parameter out of range");
    end

    // ==========================================================
    // state
    typedef struct packed {
        logic [NPRV-1:0]   act_priv;
        logic [NSH-1:0]    act_sh;
        logic [NEXT-1:0]   act_ext;
        logic [NPRV-1:0]   en_priv;
        logic [NSH-1:0]    en_sh;
        logic [NEXT-1:0]   en_ext;
        logic              ack;
        logic [DATA_W-1:0] rdata;
    } state_t;

    state_t st_reg;
    state_t st_next;

    // ==========================================================
    // address decode
    logic [ADDR_W-REGION_LSB-1:0] region;
    logic [INDEX_W-1:0]           idx;
    logic                         hit_act;
    logic                         hit_en;
    logic                         hit_ext_act;
    logic                         hit_ext_en;
    logic                         is_ext;
    logic                         is_en;
    logic                         word_ok;
    logic                         private_word;

    assign region      = i_reg_addr[ADDR_W-1:REGION_LSB];
    assign idx         = i_reg_addr[REGION_LSB-1:INDEX_LSB];
    assign hit_act     = (region == ACTIVE_CLEAR_BASE[ADDR_W-1:REGION_LSB]);
    assign hit_en      = (region == ENABLE_CLEAR_BASE[ADDR_W-1:REGION_LSB]);
    assign hit_ext_act = (region == EXT_ACTIVE_CLEAR_BASE[ADDR_W-1:REGION_LSB]);
    assign hit_ext_en  = (region == EXT_ENABLE_CLEAR_BASE[ADDR_W-1:REGION_LSB]);
    assign is_ext      = hit_ext_act | hit_ext_en;
    assign is_en       = hit_en | hit_ext_en;
    assign private_word = (idx == '0) & (hit_act | hit_en);

    // unbuilt words and elements above the banked set fall out here
    always_comb begin
        word_ok = 1'b0;
        if (hit_act || hit_en) begin
            word_ok = (int'(idx) < NUM_WORDS) &&
                      (idx != '0 || int'(i_reg_pe) < NUM_PE);
        end else if (is_ext) begin
            word_ok = EXT_SUPPORTED && (int'(idx) < EXT_WORDS);
        end
    end

    // ==========================================================
    // addressed word: attributes and current state
    logic [31:0] sel_sg;
    logic [31:0] sel_grant;
    logic [31:0] sel_state;

    always_comb begin
        int base;
        base      = 0;
        sel_sg    = '0;
        sel_grant = '0;
        sel_state = '0;
        if (word_ok) begin
            if (is_ext) begin
                base      = int'(idx) * 32;
                sel_sg    = i_secure_group_ext[base +: 32];
                sel_state = hit_ext_act ? st_reg.act_ext[base +: 32]
                                        : st_reg.en_ext[base +: 32];
            end else if (private_word) begin
                base      = int'(i_reg_pe) * 32;
                sel_sg    = i_secure_group_private;
                sel_grant = i_ns_grant_private;
                sel_state = hit_act ? st_reg.act_priv[base +: 32]
                                    : st_reg.en_priv[base +: 32];
            end else begin
                base      = (int'(idx) - 1) * 32;
                sel_sg    = i_secure_group_shared[base +: 32];
                sel_grant = i_ns_grant_shared[base +: 32];
                sel_state = hit_act ? st_reg.act_sh[base +: 32]
                                    : st_reg.en_sh[base +: 32];
            end
        end
    end

    // ==========================================================
    // per-bit access filter
    logic [31:0] acc;
    logic [31:0] sgi_fixed;

    for (genvar b = 0; b < 32; b++) begin : g_bit
        logic are_of;
        logic sec_ok;
        assign are_of = sel_sg[b] ? i_are_secure : i_are_nonsecure;
        assign sec_ok = i_security_disable | i_reg_secure | ~sel_sg[b];
        always_comb begin
            if (!word_ok) begin
                acc[b] = 1'b0;
            end else if (is_ext) begin
                acc[b] = are_of & sec_ok;
            end else if (private_word && are_of) begin
                acc[b] = 1'b0;
            end else if (is_en) begin
                acc[b] = sec_ok;
            end else begin
                acc[b] = sec_ok | sel_grant[b];
            end
        end
        if (b < 16) begin : g_sgi
            assign sgi_fixed[b] = acc[b] & SGI_ALWAYS_ON & private_word & hit_en;
        end else begin : g_other
            assign sgi_fixed[b] = 1'b0;
        end
    end

    // ==========================================================
    // clear vectors for the addressed word
    logic [31:0]     clr;
    logic [31:0]     rd_word;
    logic [NPRV-1:0] clr_act_priv;
    logic [NSH-1:0]  clr_act_sh;
    logic [NEXT-1:0] clr_act_ext;
    logic [NPRV-1:0] clr_en_priv;
    logic [NSH-1:0]  clr_en_sh;
    logic [NEXT-1:0] clr_en_ext;
    logic            spi_disable;

    assign clr     = (i_reg_valid && i_reg_write) ? (i_reg_wdata & acc & ~sgi_fixed) : '0;
    assign rd_word = (sel_state & acc) | sgi_fixed;

    always_comb begin
        int base;
        base         = 0;
        clr_act_priv = '0;
        clr_act_sh   = '0;
        clr_act_ext  = '0;
        clr_en_priv  = '0;
        clr_en_sh    = '0;
        clr_en_ext   = '0;
        if (word_ok) begin
            if (is_ext) begin
                base = int'(idx) * 32;
                if (hit_ext_act) begin
                    clr_act_ext[base +: 32] = clr;
                end else begin
                    clr_en_ext[base +: 32] = clr;
                end
            end else if (private_word) begin
                base = int'(i_reg_pe) * 32;
                if (hit_act) begin
                    clr_act_priv[base +: 32] = clr;
                end else begin
                    clr_en_priv[base +: 32] = clr;
                end
            end else begin
                base = (int'(idx) - 1) * 32;
                if (hit_act) begin
                    clr_act_sh[base +: 32] = clr;
                end else begin
                    clr_en_sh[base +: 32] = clr;
                end
            end
        end
    end

    // only shared and extended disables are tracked by the pending flag
    assign spi_disable = (|clr_en_sh) | (|clr_en_ext);

    // ==========================================================
    // next state: a set arriving with its clear wins, so no activation is lost
    always_comb begin
        st_next          = st_reg;
        st_next.act_priv = (st_reg.act_priv & ~clr_act_priv) | i_activate_private;
        st_next.act_sh   = (st_reg.act_sh & ~clr_act_sh) | i_activate_shared;
        st_next.act_ext  = (st_reg.act_ext & ~clr_act_ext) | i_activate_ext;
        st_next.en_priv  = (st_reg.en_priv & ~clr_en_priv) | i_enable_private;
        st_next.en_sh    = (st_reg.en_sh & ~clr_en_sh) | i_enable_shared;
        st_next.en_ext   = (st_reg.en_ext & ~clr_en_ext) | i_enable_ext;
        if (SGI_ALWAYS_ON) begin
            for (int p = 0; p < NUM_PE; p++) begin
                st_next.en_priv[p*32 +: 16] = SGI_BITS;
            end
        end
        st_next.ack   = i_reg_valid;
        st_next.rdata = (i_reg_valid && !i_reg_write) ? rd_word : '0;
    end

    // enables get a reset value only so control state is defined; software
    // must still program them before relying on forwarding
    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            st_reg          <= '0;
            st_reg.act_priv <= {NUM_PE{ACTIVE_RESET}};
            st_reg.en_priv  <= {NUM_PE{ENABLE_RESET}};
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // write-pending tracking
    write_pending_tracker #(
        .CYCLES          (WP_CYCLES)
    ) u_wp (
        .i_sys_clk       (i_sys_clk),
        .i_srst          (i_srst),
        .i_start         (spi_disable),
        .i_other_pending (i_other_write_pending),
        .o_pending       (o_write_pending)
    );

    // ==========================================================
    // outputs; forwarding enables never gate the active state
    assign o_reg_ack        = st_reg.ack;
    assign o_reg_rdata      = st_reg.rdata;
    assign o_active_private = st_reg.act_priv;
    assign o_active_shared  = st_reg.act_sh;
    assign o_active_ext     = st_reg.act_ext;
    assign o_enable_private = st_reg.en_priv;
    assign o_enable_shared  = st_reg.en_sh;
    assign o_enable_ext     = st_reg.en_ext;

    // ==========================================================
    // checks
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_srst);

    a_reset_active_zero: assert property (disable iff (1'b0)
        ($past(i_srst) && !i_srst) |-> (o_active_shared == '0 && o_active_ext == '0))
        else $error("active bits not zero after reset");

    a_zero_write_inert: assert property (
        (i_reg_valid && i_reg_write && i_reg_wdata == '0)
            |=> o_active_shared == $past(o_active_shared | i_activate_shared))
        else $error("zero write changed active state");

    a_clear_active: assert property (
        (|(clr_act_sh & ~i_activate_shared))
            |=> ((o_active_shared & $past(clr_act_sh & ~i_activate_shared)) == '0))
        else $error("active bit survived a clear");

    a_state_change_kept: assert property (
        (|(i_activate_shared & ~o_enable_shared))
            |=> ((o_active_shared & $past(i_activate_shared)) == $past(i_activate_shared)))
        else $error("disabled interrupt could not become active");

    a_filter_raz: assert property (
        (i_reg_valid && !i_reg_write)
            |=> (o_reg_ack && (o_reg_rdata & ~$past(acc)) == '0))
        else $error("filtered bit read as one");

    a_private_are_wi: assert property (
        (i_reg_valid && i_reg_write && private_word && i_are_secure && i_are_nonsecure)
            |=> (o_active_private & ~$past(i_activate_private)) ==
                ($past(o_active_private) & ~$past(i_activate_private)))
        else $error("private bit changed under affinity routing");

    a_ns_secure_hidden: assert property (
        (i_reg_valid && !i_reg_write && is_en && !i_reg_secure && !i_security_disable)
            |=> ((o_reg_rdata & $past(sel_sg)) == '0))
        else $error("secure enable bit visible to non-secure read");

    a_enable_read_zero: assert property (
        (i_reg_valid && i_reg_write && hit_en && idx == 5'h01 && (|clr) &&
         !(|i_enable_shared)) ##1 (!i_reg_valid && !(|i_enable_shared)) ##1
        (i_reg_valid && !i_reg_write && hit_en &&
         idx == 5'h01 && !(|i_enable_shared) && $stable(i_reg_pe))
            |=> ((o_reg_rdata & $past(clr, 3)) == '0))
        else $error("enable bit read one after clear");

    a_disable_flags_pending: assert property (
        spi_disable |=> o_write_pending)
        else $error("disable not reported as pending");

    a_ext_absent: assert property (
        (i_reg_valid && !i_reg_write && is_ext && !word_ok) |=> o_reg_rdata == '0)
        else $error("extended word readable without support");

endmodule

// >>> rtl/dist_clear_pkg.sv
// constants for the distributor clear-active and clear-enable word arrays
package dist_clear_pkg;

    // ==========================================================
    // register bus geometry
    localparam int ADDR_W   = 16;
    localparam int DATA_W   = 32;
    localparam int PE_NUM_W = 4;
    localparam int MAX_PE   = 8;
    localparam int MAX_WORDS = 32;

    // ==========================================================
    // word array bases; each array spans 32 words (0x80 bytes)
    localparam logic [ADDR_W-1:0] ENABLE_CLEAR_BASE     = 16'h0180;
    localparam logic [ADDR_W-1:0] ACTIVE_CLEAR_BASE     = 16'h0380;
    localparam logic [ADDR_W-1:0] EXT_ENABLE_CLEAR_BASE = 16'h1400;
    localparam logic [ADDR_W-1:0] EXT_ACTIVE_CLEAR_BASE = 16'h1C00;
    localparam int                REGION_LSB            = 7;
    localparam int                INDEX_LSB             = 2;
    localparam int                INDEX_W               = 5;
    localparam int                EXT_ID_BASE           = 4096;

    // ==========================================================
    // reset values
    localparam logic [DATA_W-1:0] ACTIVE_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] ENABLE_RESET = 32'h0000_0000;
    localparam logic [15:0]       SGI_BITS     = 16'hFFFF;

    // ==========================================================
    // disable propagation time through the affinity hierarchy
    localparam int CLK_PERIOD_NS    = 40;
    localparam int PROPAGATE_NS     = 200;
    localparam int PROPAGATE_CYCLES = (PROPAGATE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W            = 8;

endpackage

// >>> rtl/write_pending_tracker.sv
// write-pending tracker: holds the flag while a forwarding disable propagates
`timescale 1ns/1ps
module write_pending_tracker
    import dist_clear_pkg::*;
#(
    parameter int CYCLES = PROPAGATE_CYCLES
)(
    // clock and reset
    input  wire logic i_sys_clk,
    input  wire logic i_srst,
    // tracked events
    input  wire logic i_start,
    input  wire logic i_other_pending,
    // status
    output logic      o_pending
);

    // ==========================================================
    // elaboration check
    if (CYCLES < 1 || CYCLES > 255) begin : g_bad_cycles
        $error("write_pending_tracker: CYCLES out of range");
    end

    // ==========================================================
    // state
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic             pending;
    } wp_state_t;

    wp_state_t wp_reg;
    wp_state_t wp_next;

    always_comb begin
        wp_next = wp_reg;
        // a new disable restarts the full wait, so the flag covers the latest one
        if (i_start) begin
            wp_next.cnt = CNT_W'(CYCLES);
        end else if (wp_reg.cnt != '0) begin
            wp_next.cnt = wp_reg.cnt - 1'b1;
        end
        wp_next.pending = (wp_next.cnt != '0) | i_other_pending;
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_srst) begin
            wp_reg <= '0;
        end else begin
            wp_reg <= wp_next;
        end
    end

    assign o_pending = wp_reg.pending;

    // ==========================================================
    // checks
    sequence s_disable_seen;
        i_start;
    endsequence

    sequence s_flag_held;
        o_pending [*4];
    endsequence

    a_wp_flag_held: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        s_disable_seen |=> s_flag_held)
        else $error("write pending dropped before propagation time");

    a_wp_flag_drops: assert property (@(posedge i_sys_clk) disable iff (i_srst)
        (i_start && !i_other_pending) ##1 (!i_start && !i_other_pending) [*6]
            |-> !o_pending)
        else $error("write pending stuck after propagation");

endmodule

// >>> bench/pe_access_model.sv
// processing element model issuing distributor register accesses
`timescale 1ns/1ps
module pe_access_model
    import dist_clear_pkg::*;
(
    // clock and answer
    input  wire logic                i_sys_clk,
    input  wire logic                i_reg_ack,
    input  wire logic [DATA_W-1:0]   i_reg_rdata,
    // request
    output logic                     o_reg_valid,
    output logic                     o_reg_write,
    output logic [ADDR_W-1:0]        o_reg_addr,
    output logic [DATA_W-1:0]        o_reg_wdata,
    output logic                     o_reg_secure,
    output logic [PE_NUM_W-1:0]      o_reg_pe
);
    // ==========================================================
    // access task
    initial {o_reg_valid, o_reg_write, o_reg_addr, o_reg_wdata, o_reg_secure, o_reg_pe} = '0;
    // every access carries its secure attribute and processor number
    task automatic access(input logic w, input logic [ADDR_W-1:0] a,
                          input logic [DATA_W-1:0] d, input logic s,
                          input logic [PE_NUM_W-1:0] p, output logic [DATA_W-1:0] q,
                          output logic ok);
        @(negedge i_sys_clk);
        {o_reg_valid, o_reg_write, o_reg_addr, o_reg_wdata, o_reg_secure, o_reg_pe} =
            {1'b1, w, a, d, s, p};
        @(negedge i_sys_clk);
        o_reg_valid = 1'b0;
        // idle data must not look like the last word
        o_reg_wdata = ~d;
        q = i_reg_rdata;
        ok = (i_reg_ack === 1'b1);
    endtask
endmodule

// >>> bench/distributor_clear_active_enable_test.sv
// self-checking bench for the clear-active and clear-enable word arrays
`timescale 1ns/1ps
module distributor_clear_active_enable_test;
    import dist_clear_pkg::*;
    // ==========================================================
    // signals
    localparam int WP = 5;
    typedef struct packed {
        logic [ADDR_W-1:0]   addr;
        logic [2:0]          f;
        logic [PE_NUM_W-1:0] pe;
        logic [PE_NUM_W-1:0] rpe;
        logic [DATA_W-1:0]   w;
        logic [DATA_W-1:0]   exp;
    } row_t;
    logic                clk = 1'b0;
    logic                srst = 1'b1;
    logic                ds = 1'b0;
    logic                ar = 1'b0;
    logic                act = 1'b0;
    logic                en = 1'b0;
    logic                other = 1'b0;
    logic [DATA_W-1:0]   grp = 32'h000000FF;
    logic                valid, write, sec, ack, wp, ok;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   wdata, rdata, q;
    logic [PE_NUM_W-1:0] pe;
    logic [63:0]         act_prv, en_prv;
    logic [31:0]         act_sh, act_ex, en_sh, en_ex;
    int                  n_mismatch = 0;
    int                  checked = 0;
    int                  n;
    row_t                r;
    // f is {secure, security disable, affinity routing}
    row_t rows [16] = '{
        '{16'h0180, 3'h4, 4'h0, 4'h0, 32'h0000F0F0, 32'hFFFF0F0F},
        '{16'h0180, 3'h0, 4'h0, 4'h0, 32'h0F00000F, 32'hF0FFFF00},
        '{16'h0180, 3'h4, 4'h0, 4'h1, 32'hFFFFFFFF, 32'hFFFFFFFF},
        '{16'h0180, 3'h4, 4'h3, 4'h3, 32'h00000000, 32'h00000000},
        '{16'h0184, 3'h4, 4'h0, 4'h0, 32'h00000001, 32'hFFFFFFFE},
        '{16'h0184, 3'h2, 4'h0, 4'h0, 32'h000000F0, 32'hFFFFFF0F},
        '{16'h0380, 3'h0, 4'h0, 4'h0, 32'h00000011, 32'hFFFFFF0E},
        '{16'h0384, 3'h4, 4'h0, 4'h0, 32'h80000000, 32'h7FFFFFFF},
        '{16'h0384, 3'h4, 4'h0, 4'h0, 32'h00000000, 32'hFFFFFFFF},
        '{16'h0380, 3'h5, 4'h0, 4'h0, 32'h00000000, 32'h00000000},
        '{16'h0180, 3'h5, 4'h0, 4'h0, 32'h00000000, 32'h00000000},
        '{16'h1C00, 3'h5, 4'h0, 4'h0, 32'h00000100, 32'hFFFFFEFF},
        '{16'h1C00, 3'h4, 4'h0, 4'h0, 32'h00000000, 32'h00000000},
        '{16'h1400, 3'h1, 4'h0, 4'h0, 32'h0000FF00, 32'hFFFF0000},
        '{16'h1C04, 3'h5, 4'h0, 4'h0, 32'h00000000, 32'h00000000},
        '{16'h0000, 3'h4, 4'h0, 4'h0, 32'h00000000, 32'h00000000}
    };
    always #20 clk = ~clk;
    clear_active_enable #(.NUM_PE(2)) dut_u (
        .i_sys_clk(clk), .i_srst(srst), .i_reg_valid(valid), .i_reg_write(write),
        .i_reg_addr(addr), .i_reg_wdata(wdata), .i_reg_secure(sec), .i_reg_pe(pe),
        .o_reg_ack(ack), .o_reg_rdata(rdata), .i_security_disable(ds), .i_are_secure(ar),
        .i_are_nonsecure(ar), .i_other_write_pending(other), .o_write_pending(wp),
        .i_secure_group_private(grp), .i_secure_group_shared(grp), .i_secure_group_ext(grp),
        .i_ns_grant_private(32'h0000000F), .i_ns_grant_shared(32'h00000000),
        .i_activate_private({64{act}}), .i_activate_shared({32{act}}),
        .i_activate_ext({32{act}}), .i_enable_private({64{en}}),
        .i_enable_shared({32{en}}), .i_enable_ext({32{en}}), .o_active_private(act_prv),
        .o_active_shared(act_sh), .o_active_ext(act_ex), .o_enable_private(en_prv),
        .o_enable_shared(en_sh), .o_enable_ext(en_ex)
    );
    pe_access_model pe_u (
        .i_sys_clk(clk), .i_reg_ack(ack), .i_reg_rdata(rdata), .o_reg_valid(valid),
        .o_reg_write(write), .o_reg_addr(addr), .o_reg_wdata(wdata), .o_reg_secure(sec),
        .o_reg_pe(pe)
    );
    // ==========================================================
    // tasks
    task automatic chk(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] s);
        checked++;
        if (s !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic chkb(input string nm, input logic e, input logic s);
        chk(nm, {31'h0, e}, {31'h0, s});
    endtask
    task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                       input logic s, input logic [PE_NUM_W-1:0] p);
        pe_u.access(w, a, d, s, p, q, ok);
        chkb("ack", 1'b1, ok);
    endtask
    // one-cycle set pulse puts every interrupt active and forwarded
    task automatic set_all(input logic [2:0] f);
        @(negedge clk);
        {ds, ar} = f[1:0];
        act = 1'b1;
        en = 1'b1;
        @(negedge clk);
        act = 1'b0;
        en = 1'b0;
    endtask
    task automatic do_reset();
        srst = 1'b1;
        repeat (12) @(negedge clk);
        srst = 1'b0;
        @(negedge clk);
    endtask
    task automatic complete_run();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ==========================================================
    // sequence
    initial begin
        do_reset();
        for (int i = 0; i < 16; i++) begin
            r = rows[i];
            set_all(r.f);
            acc(1'b1, r.addr, r.w, r.f[2], r.pe);
            acc(1'b0, r.addr, '0, r.f[2], r.rpe);
            chk("row read", r.exp, q);
            $display("row %0d done", i);
        end
        set_all(3'h4);
        acc(1'b1, 16'h0184, 32'h00000001, 1'b1, 4'h0);
        chkb("pending set", 1'b1, wp);
        other = 1'b1;
        repeat (WP + 3) @(negedge clk);
        chkb("pending held", 1'b1, wp);
        other = 1'b0;
        n = 0;
        while (wp === 1'b1 && n < WP + 2) begin
            @(negedge clk);
            n++;
        end
        chkb("pending clear", 1'b0, wp);
        acc(1'b1, 16'h0180, 32'h00000001, 1'b1, 4'h0);
        chkb("private untracked", 1'b0, wp);
        chk("enable private", 32'hFFFFFFFE, en_prv[31:0]);
        chk("enable bank 1", 32'hFFFFFFFF, en_prv[63:32]);
        chk("enable shared", 32'hFFFFFFFE, en_sh);
        $display("write pending test done");
        // clear the shared actives, then reactivate while forwarding of id 32 is off
        acc(1'b1, 16'h0384, 32'hFFFFFFFF, 1'b1, 4'h0);
        chk("active cleared", 32'h00000000, act_sh);
        @(negedge clk);
        act = 1'b1;
        @(negedge clk);
        act = 1'b0;
        chk("active while disabled", 32'hFFFFFFFF, act_sh);
        ar = 1'b1;
        acc(1'b1, 16'h1400, 32'h0000FF00, 1'b1, 4'h0);
        chk("enable ext", 32'hFFFF00FF, en_ex);
        $display("state output test done");
        // reset in mid-run must drop the active state set above
        do_reset();
        chk("reset private out", 32'h00000000, act_prv[31:0]);
        chk("reset ext out", 32'h00000000, act_ex);
        acc(1'b0, 16'h0384, '0, 1'b1, 4'h0);
        chk("reset active", 32'h00000000, q);
        ar = 1'b1;
        acc(1'b0, 16'h1C00, '0, 1'b1, 4'h0);
        chk("reset ext active", 32'h00000000, q);
        $display("reset test done");
        complete_run();
    end
    initial begin
        repeat (20000) @(negedge clk);
        n_mismatch++;
        complete_run();
    end
endmodule
